// ==== hw/cpsm_pkg.sv ====
// Constants and types shared by the cell protection state machine
package cpsm_pkg;

   // Core clock and slow delay clock rates
   localparam int CORE_CLK_HZ = 200_000_000;
   localparam int SLOW_CLK_HZ = 4_000;
   // Core cycles per slow tick (50000)
   localparam int TICK_DIV_DEFAULT = CORE_CLK_HZ / SLOW_CLK_HZ;

   // Detection delays in milliseconds, plain defaults
   localparam int OVERCHARGE_DELAY_MS    = 1000;
   localparam int OVERDISCHARGE_DELAY_MS = 128;
   // Same delays as counts of slow ticks
   localparam int OVERCHARGE_DELAY_TICKS    = OVERCHARGE_DELAY_MS * SLOW_CLK_HZ / 1000;
   localparam int OVERDISCHARGE_DELAY_TICKS = OVERDISCHARGE_DELAY_MS * SLOW_CLK_HZ / 1000;

   // Width of the divider and delay counters
   localparam int CNT_W = 16;

   // Positions of the comparator results inside the synchroniser
   localparam int CMP_ABOVE_OC     = 0;
   localparam int CMP_BELOW_OC_REL = 1;
   localparam int CMP_BELOW_OD     = 2;
   localparam int CMP_AT_OD_REL    = 3;
   localparam int CMP_DIS_OVERCUR  = 4;
   localparam int CMP_CHG_OVERCUR  = 5;
   localparam int CMP_OVERHEAT     = 6;
   localparam int CMP_LS_GE_0P35   = 7;
   localparam int CMP_LS_GE_0P7    = 8;
   localparam int CMP_LS_BELOW_0V  = 9;
   localparam int CMP_N            = 10;

   // Protection states, one-hot
   typedef enum logic [2:0]
   {
      ST_NORMAL        = 3'h1,
      ST_OVERCHARGE    = 3'h2,
      ST_OVERDISCHARGE = 3'h4
   } cpsm_state_t;

endpackage

// ==== hw/cpsm_delay.sv ====
// Detection delay counter clocked by core_clk, advanced by the slow tick
`timescale 1ns/100ps
`default_nettype none
module cpsm_delay
   import cpsm_pkg::*;
#(
   parameter int TICKS = 4
)
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic tick,     // One-cycle slow clock enable
   input  wire logic cond,     // Triggering comparator condition
   output var  logic expired   // Condition held for the full delay
);

   logic [CNT_W-1:0] count;    // Ticks seen while cond held

   // Count ticks while cond holds; any gap restarts from zero
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         count <= '0;
      end
      else if (!cond)
      begin
         count <= '0;
      end
      else if (tick && !expired)
      begin
         count <= count + 1'b1;
      end
   end

   // Expiry flag stays up while the condition stays true
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         expired <= 1'b0;
      end
      else if (!cond)
      begin
         expired <= 1'b0;
      end
      else if (tick && (count == CNT_W'(TICKS - 1)))
      begin
         expired <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_delay_restart: assert property (!cond |=> count == '0 && !expired)
      else $error("delay counter did not restart");
   chk_delay_no_early: assert property ($rose(expired) |-> $past(count) == CNT_W'(TICKS - 1))
      else $error("delay expired early");

endmodule
`default_nettype wire

// ==== hw/cpsm_top.sv ====
// Protection state machine of a one-cell battery guard
// Operation
// - Normal range: both gates on
// - Normal: monitor resistor on, pulls off
// - Overcharge after delay above threshold; charge off
// - Separate release, low load-sense: below release
// - Load-sense high: release below overcharge threshold
// - Equal option: release needs load-sense high
// - Overcurrent ignored in overcharge while above overcharge threshold
// - Overdischarge after delay below; discharge off
// - Overdischarge: pull-up on, pull-down off
// - Charger below 0V: release at detection
// - Power-down at 0.7V load-sense, exit below
// - Power-down option: stay while load-sense high
// - No power-down option: release at release threshold
// - Delays counted on 4 kHz internal tick
`timescale 1ns/100ps
`default_nettype none
module cpsm_top
   import cpsm_pkg::*;
#(
   parameter bit SEPARATE_RELEASE = 1'b1,  // Release threshold below detection
   parameter bit POWER_DOWN_OPT   = 1'b1,  // Power-down function present
   parameter int TICK_DIV         = TICK_DIV_DEFAULT,
   parameter int OC_DELAY_TICKS   = OVERCHARGE_DELAY_TICKS,
   parameter int OD_DELAY_TICKS   = OVERDISCHARGE_DELAY_TICKS
)
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic cell_above_overcharge,       // Cell above overcharge_threshold
   input  wire logic cell_below_overcharge_rel,   // Cell below overcharge_release_threshold
   input  wire logic cell_below_overdischarge,    // Cell below overdischarge_threshold
   input  wire logic cell_at_overdischarge_rel,   // Cell at or above overdischarge release
   input  wire logic current_over_discharge,      // Sense at discharge_overcurrent_limit
   input  wire logic current_over_charge,         // Sense at charge_overcurrent_limit
   input  wire logic temp_over_overheat,          // Above overheat_threshold
   input  wire logic load_sense_ge_0p35,          // load_sense_pin at or above 0.35 V
   input  wire logic load_sense_ge_0p7,           // load_sense_pin at or above 0.7 V
   input  wire logic load_sense_below_0v,         // load_sense_pin below 0 V
   output var  logic charge_gate_out,             // Charge FET gate on
   output var  logic discharge_gate_out,          // Discharge FET gate on
   output var  logic monitor_ground_on,           // monitor_ground_resistor connected
   output var  logic load_sense_pullup_on,        // load_sense_pullup connected
   output var  logic load_sense_pulldown_on,      // load_sense_pulldown connected
   output var  logic power_down,                  // Power-down entered
   output var  logic overcurrent_detect_en,       // Discharge overcurrent may act
   output var  logic in_overcharge,               // State flag
   output var  logic in_overdischarge             // State flag
);

   // Comparator results arrive from the analog side, asynchronous
   logic [CMP_N-1:0] cmp_raw;    // Raw comparator vector, highest index first
   logic [CMP_N-1:0] cmp_meta;   // First synchroniser stage
   logic [CMP_N-1:0] cmp;        // Second stage, safe to use

   // Order follows the package positions, bit 9 down to bit 0
   assign cmp_raw = {load_sense_below_0v, load_sense_ge_0p7, load_sense_ge_0p35, temp_over_overheat,
                     current_over_charge, current_over_discharge, cell_at_overdischarge_rel,
                     cell_below_overdischarge, cell_below_overcharge_rel, cell_above_overcharge};

   // Two-flop synchroniser; only the second stage feeds logic
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cmp_meta <= '0;
         cmp      <= '0;
      end
      else
      begin
         cmp_meta <= cmp_raw;
         cmp      <= cmp_meta;
      end
   end

   // Named views of the synchronised comparators
   wire logic above_oc  = cmp[CMP_ABOVE_OC];      // Cell above overcharge threshold
   wire logic below_ocr = cmp[CMP_BELOW_OC_REL];  // Cell below overcharge release
   wire logic below_od  = cmp[CMP_BELOW_OD];      // Cell below overdischarge threshold
   wire logic at_odr    = cmp[CMP_AT_OD_REL];     // Cell at overdischarge release
   wire logic i_dis     = cmp[CMP_DIS_OVERCUR];   // Discharge overcurrent comparator
   wire logic i_chg     = cmp[CMP_CHG_OVERCUR];   // Charge overcurrent comparator
   wire logic hot       = cmp[CMP_OVERHEAT];      // Overheat comparator
   wire logic ls_0p35   = cmp[CMP_LS_GE_0P35];    // Load-sense at 0.35 V or more
   wire logic ls_0p7    = cmp[CMP_LS_GE_0P7];     // Load-sense at 0.7 V or more
   wire logic ls_neg    = cmp[CMP_LS_BELOW_0V];   // Load-sense below 0 V, charger present

   // Slow tick divider; the analog original runs a 4 kHz oscillator
   logic [CNT_W-1:0] div_count;  // Core cycles within one slow period
   logic             tick;       // One-cycle enable at the slow rate

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         div_count <= '0;
         tick      <= 1'b0;
      end
      else if (div_count == CNT_W'(TICK_DIV - 1))
      begin
         div_count <= '0;
         tick      <= 1'b1;
      end
      else
      begin
         div_count <= div_count + 1'b1;
         tick      <= 1'b0;
      end
   end

   // State register and its next value
   cpsm_state_t state;
   cpsm_state_t next_state;

   // Delay counters see their condition only in the normal state,
   // so a detour through another state always starts afresh
   logic oc_cond;      // Overcharge detection pending
   logic od_cond;      // Overdischarge detection pending
   logic oc_expired;   // Overcharge delay served
   logic od_expired;   // Overdischarge delay served

   assign oc_cond = (state == ST_NORMAL) && above_oc;
   assign od_cond = (state == ST_NORMAL) && below_od;

   cpsm_delay #(.TICKS(OC_DELAY_TICKS)) u_oc_delay
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .cond     (oc_cond),
      .expired  (oc_expired)
   );

   cpsm_delay #(.TICKS(OD_DELAY_TICKS)) u_od_delay
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .cond     (od_cond),
      .expired  (od_expired)
   );

   // Release decisions for each protection state
   logic oc_release;   // Leave overcharge this cycle
   logic od_release;   // Leave overdischarge this cycle

   // Load through the body diode lifts load-sense; a charger alone never releases the equal option
   assign oc_release = ls_0p35 ? !above_oc
                     : (SEPARATE_RELEASE && below_ocr);
   // Negative load-sense means a charger; without one the power-down variant holds while load-sense is at 0.7 V or more
   assign od_release = ls_neg ? !below_od
                     : (POWER_DOWN_OPT && ls_0p7) ? 1'b0
                     : at_odr;

   // Next-state decision; overcharge wins if both delays expire at once
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_NORMAL:
         begin
            if (oc_expired)
            begin
               next_state = ST_OVERCHARGE;
            end
            else if (od_expired)
            begin
               next_state = ST_OVERDISCHARGE;
            end
         end
         ST_OVERCHARGE:
         begin
            if (oc_release)
            begin
               next_state = ST_NORMAL;
            end
         end
         ST_OVERDISCHARGE:
         begin
            if (od_release)
            begin
               next_state = ST_NORMAL;
            end
         end
         default:
         begin
            next_state = ST_NORMAL;  // Recover from an illegal code
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_NORMAL;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Gate drive: overcurrent and overheat states live elsewhere,
   // here the gates simply drop when the normal window is left
   logic ok_window;    // Current and temperature inside limits

   assign ok_window = !i_dis && !i_chg && !hot;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         charge_gate_out    <= 1'b0;
         discharge_gate_out <= 1'b0;
      end
      else
      begin
         charge_gate_out    <= (state == ST_NORMAL) && ok_window;
         discharge_gate_out <= (state == ST_NORMAL) && ok_window;
      end
   end

   // Internal resistor switches
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         monitor_ground_on      <= 1'b0;
         load_sense_pullup_on   <= 1'b0;
         load_sense_pulldown_on <= 1'b0;
      end
      else
      begin
         // Monitor resistor also returns with a charger in overdischarge
         monitor_ground_on      <= (state == ST_NORMAL) ||
                                   ((state == ST_OVERDISCHARGE) && ls_neg);
         load_sense_pullup_on   <= (state == ST_OVERDISCHARGE);
         load_sense_pulldown_on <= 1'b0;
      end
   end

   // Power-down follows load-sense level while overdischarged
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         power_down <= 1'b0;
      end
      else
      begin
         power_down <= POWER_DOWN_OPT && (state == ST_OVERDISCHARGE) && ls_0p7;
      end
   end

   // Status flags and overcurrent permission
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         overcurrent_detect_en <= 1'b0;
         in_overcharge         <= 1'b0;
         in_overdischarge      <= 1'b0;
      end
      else
      begin
         // Heavy load cannot trip in overcharge while cell still sits above threshold
         overcurrent_detect_en <= !((state == ST_OVERCHARGE) && above_oc);
         in_overcharge         <= (state == ST_OVERCHARGE);
         in_overdischarge      <= (state == ST_OVERDISCHARGE);
      end
   end

   // Helper: cycles since the last tick, read only by assertions
   logic [CNT_W-1:0] since_tick;
   logic             seen_tick;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         since_tick <= '0;
         seen_tick  <= 1'b0;
      end
      else if (tick)
      begin
         since_tick <= '0;
         seen_tick  <= 1'b1;
      end
      else
      begin
         since_tick <= since_tick + 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_tick_spacing: assert property (tick && seen_tick |-> since_tick == CNT_W'(TICK_DIV - 1))
      else $error("slow tick spacing wrong");
   chk_normal_gates: assert property (state == ST_NORMAL && ok_window |=> charge_gate_out && discharge_gate_out)
      else $error("gates not on in normal window");
   chk_normal_resist: assert property (state == ST_NORMAL |=> monitor_ground_on && !load_sense_pullup_on && !load_sense_pulldown_on)
      else $error("normal resistor setting wrong");
   chk_oc_entry: assert property (state == ST_NORMAL && oc_expired |=> state == ST_OVERCHARGE ##1 !charge_gate_out)
      else $error("overcharge not entered");
   chk_oc_hold_sep: assert property (state == ST_OVERCHARGE && SEPARATE_RELEASE && !ls_0p35 && !below_ocr |=> state == ST_OVERCHARGE)
      else $error("overcharge released above release threshold");
   chk_oc_rel_load: assert property (state == ST_OVERCHARGE && ls_0p35 && !above_oc |=> state == ST_NORMAL)
      else $error("overcharge not released with load");
   chk_oc_hold_equal: assert property (state == ST_OVERCHARGE && !SEPARATE_RELEASE && !ls_0p35 |=> state == ST_OVERCHARGE)
      else $error("equal option released by charger");
   chk_oc_no_overcur: assert property (state == ST_OVERCHARGE && above_oc |=> !overcurrent_detect_en)
      else $error("overcurrent enabled above threshold");
   chk_od_entry: assert property (state == ST_NORMAL && od_expired && !oc_expired |=> state == ST_OVERDISCHARGE ##1 !discharge_gate_out)
      else $error("overdischarge not entered");
   chk_od_resist: assert property (state == ST_OVERDISCHARGE |=> load_sense_pullup_on && !load_sense_pulldown_on)
      else $error("overdischarge pull setting wrong");
   chk_od_rel_charger: assert property (state == ST_OVERDISCHARGE && ls_neg && !below_od |=> state == ST_NORMAL)
      else $error("overdischarge not released with charger");
   chk_pd_enter: assert property (state == ST_OVERDISCHARGE && POWER_DOWN_OPT && ls_0p7 |=> power_down)
      else $error("power-down not entered");
   chk_pd_hold: assert property (state == ST_OVERDISCHARGE && POWER_DOWN_OPT && ls_0p7 && !ls_neg |=> state == ST_OVERDISCHARGE)
      else $error("released while powered down");
   chk_no_pd: assert property (!POWER_DOWN_OPT |-> !power_down)
      else $error("power-down without option");
   chk_od_rel_nopd: assert property (state == ST_OVERDISCHARGE && !POWER_DOWN_OPT && !ls_neg && at_odr |=> state == ST_NORMAL)
      else $error("overdischarge not released at release threshold");

   cov_overcharge: cover property (state == ST_OVERCHARGE ##1 state == ST_NORMAL);
   cov_overdischarge: cover property (state == ST_OVERDISCHARGE ##1 state == ST_NORMAL);
   cov_power_down: cover property ($rose(power_down));
   cov_restart: cover property (oc_cond ##1 !oc_cond ##1 oc_cond);

endmodule
`default_nettype wire

// ==== testbench/cpsm_cell_model.sv ====
// Behavioural cell, charger and load that feed the comparator inputs
`timescale 1ns/100ps
`default_nettype none
module cpsm_cell_model
   import cpsm_pkg::*;
#(
   parameter int OC_MV     = 4200,  // overcharge_threshold
   parameter int OC_REL_MV = 4100,  // overcharge_release_threshold
   parameter int OD_MV     = 2500,  // overdischarge_threshold
   parameter int OD_REL_MV = 2900,  // overdischarge_release_threshold
   parameter int DIS_MV    = 50,    // discharge_overcurrent_limit
   parameter int CHG_MV    = -50,   // charge_overcurrent_limit
   parameter int HOT_C     = 60     // overheat_threshold
)
(
   input  var  int               cell_mv,    // Cell voltage in mV
   input  var  int               ls_mv,      // Load sense set by charger or load
   input  var  int               cur_mv,     // Current sense in mV
   input  var  int               temp_c,     // Thermistor temperature
   input  wire logic             open_load,  // Terminals left open
   input  wire logic             pullup_on,  // Device pull-up state
   output var  logic [CMP_N-1:0] cmp         // Comparator results
);
   int ls_now;  // Voltage seen on load_sense_pin

   // With open terminals only the pull-up lifts load sense; otherwise it sits at ground
   always_comb
   begin
      if (open_load)
         ls_now = pullup_on ? cell_mv : 0;
      else
         ls_now = ls_mv;
   end

   // Ideal comparators; the device resynchronises them, so no timing is modelled
   always_comb
   begin
      cmp                   = '0;
      cmp[CMP_ABOVE_OC]     = cell_mv > OC_MV;
      cmp[CMP_BELOW_OC_REL] = cell_mv < OC_REL_MV;
      cmp[CMP_BELOW_OD]     = cell_mv < OD_MV;
      cmp[CMP_AT_OD_REL]    = cell_mv >= OD_REL_MV;
      cmp[CMP_DIS_OVERCUR]  = cur_mv >= DIS_MV;
      cmp[CMP_CHG_OVERCUR]  = cur_mv <= CHG_MV;
      cmp[CMP_OVERHEAT]     = temp_c > HOT_C;
      cmp[CMP_LS_GE_0P35]   = ls_now >= 350;
      cmp[CMP_LS_GE_0P7]    = ls_now >= 700;
      cmp[CMP_LS_BELOW_0V]  = ls_now < 0;
   end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the cell protection state machine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cpsm_pkg::*;
   localparam int DIV = 4;            // Shortened slow tick divider
   logic             core_clk;        // 200 MHz clock
   logic             rst_n;           // Sync reset, active low
   int               cell_mv;         // Cell voltage
   int               ls_mv;           // Load sense with charger or load attached
   int               cur_mv;          // Current sense
   int               temp_c;          // Temperature
   logic             open_load;       // Nothing attached
   logic [CMP_N-1:0] cmp;             // Comparator results
   logic [1:0]       cg, dg, mon, pu; // Index 0: separate release, power-down
   logic [1:0]       pd, pdn, ocd;    // Index 1: equal thresholds, no power-down
   logic [1:0]       ovc, ovd;        // State flags
   int               err_total;       // Mismatches
   int               total_checks;    // Comparisons made

   // Both product options watch the same cell
   for (genvar i = 0; i < 2; i++)
   begin : g_dut
      cpsm_top #(.SEPARATE_RELEASE(i == 0), .POWER_DOWN_OPT(i == 0), .TICK_DIV(DIV),
                 .OC_DELAY_TICKS(3), .OD_DELAY_TICKS(2))
      cpsm_top_inst (.core_clk(core_clk), .rst_n(rst_n),
         .cell_above_overcharge(cmp[CMP_ABOVE_OC]), .cell_below_overcharge_rel(cmp[CMP_BELOW_OC_REL]),
         .cell_below_overdischarge(cmp[CMP_BELOW_OD]), .cell_at_overdischarge_rel(cmp[CMP_AT_OD_REL]),
         .current_over_discharge(cmp[CMP_DIS_OVERCUR]), .current_over_charge(cmp[CMP_CHG_OVERCUR]),
         .temp_over_overheat(cmp[CMP_OVERHEAT]), .load_sense_ge_0p35(cmp[CMP_LS_GE_0P35]),
         .load_sense_ge_0p7(cmp[CMP_LS_GE_0P7]), .load_sense_below_0v(cmp[CMP_LS_BELOW_0V]),
         .charge_gate_out(cg[i]), .discharge_gate_out(dg[i]), .monitor_ground_on(mon[i]),
         .load_sense_pullup_on(pu[i]), .load_sense_pulldown_on(pd[i]), .power_down(pdn[i]),
         .overcurrent_detect_en(ocd[i]), .in_overcharge(ovc[i]), .in_overdischarge(ovd[i]));
   end

   // Pull-up of the power-down variant decides the open-terminal level
   cpsm_cell_model cpsm_cell_model_inst (.cell_mv(cell_mv), .ls_mv(ls_mv), .cur_mv(cur_mv),
      .temp_c(temp_c), .open_load(open_load), .pullup_on(pu[0]), .cmp(cmp));

   // Free-running clock
   always #2.5 core_clk = ~core_clk;

   // Verdict and end of run
   task automatic report_and_stop;
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Compare one value, counting every call
   task automatic chk(input string nm, input logic seen, input logic exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %b seen %b", nm, exp, seen);
      end
   endtask

   // Step n edges, then move off the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Selects a watched output pair
   function automatic logic [1:0] pick(input int sel);
      case (sel)
         0:       return ovc;
         1:       return ovd;
         default: return pdn;
      endcase
   endfunction

   // Bounded wait for an output pair; a timeout ends the run
   task automatic wait_for(input int sel, input logic [1:0] val, output int n);
      n = 0;
      while (pick(sel) !== val && n < 80)
      begin
         cyc(1);
         n++;
      end
      total_checks++;
      if (n == 80)
      begin
         err_total++;
         $display("mismatch wait %0d expected %b seen %b", sel, val, pick(sel));
         report_and_stop();
      end
   endtask

   // Normal state outputs after reset
   task automatic t_normal;
      cyc(3);
      chk("gates_on", &{cg, dg}, 1'b1);
      chk("monitor_on", &mon, 1'b1);
      chk("pulls_off", |{pu, pd}, 1'b0);
   endtask

   // Any overcurrent or overheat comparator drops the gates
   task automatic t_gates_off;
      for (int k = 0; k < 3; k++)
      begin
         cur_mv = (k == 0) ? 60 : (k == 1) ? -60 : 0;
         temp_c = (k == 2) ? 70 : 25;
         cyc(6);
         chk("gates_off", |{cg, dg}, 1'b0);
         cur_mv = 0;
         temp_c = 25;
         cyc(6);
         chk("gates_back", &{cg, dg}, 1'b1);
      end
   endtask

   // Interrupted overvoltage must never accumulate into a detection
   task automatic t_glitch;
      repeat (4)
      begin
         cell_mv = 4300;
         cyc(7);
         cell_mv = 3700;
         cyc(8);
      end
      chk("no_overcharge", |ovc, 1'b0);
   endtask

   // Overcharge entry with a lower and upper bound on the delay
   task automatic enter_oc;
      int n;
      cell_mv = 4300;
      cyc(8);
      chk("oc_early", |ovc, 1'b0);
      wait_for(0, 2'b11, n);
      chk("oc_delay", n <= 10, 1'b1);
      chk("charge_off", |cg, 1'b0);
      chk("ocd_blocked", |ocd, 1'b0);
      chk("oc_monitor_off", |mon, 1'b0);
   endtask

   // Release paths of both overcharge options
   task automatic t_oc_release;
      int n;
      enter_oc();
      cell_mv = 4150;
      cyc(30);
      chk("oc_hold", &ovc, 1'b1);
      chk("ocd_below", &ocd, 1'b1);
      cell_mv = 4000;
      wait_for(0, 2'b10, n);
      cyc(30);
      chk("equal_hold", ovc[1], 1'b1);
      ls_mv = 400;
      wait_for(0, 2'b00, n);
      cyc(2);
      chk("gates_after", &{cg, dg}, 1'b1);
      cell_mv = 3700;
      enter_oc();
      cell_mv = 4150;
      wait_for(0, 2'b00, n);
      ls_mv = 0;
      cell_mv = 3700;
      cyc(4);
   endtask

   // Overdischarge entry, power-down and the three release conditions
   task automatic t_od;
      int n;
      cell_mv = 2400;
      cyc(4);
      chk("od_early", |ovd, 1'b0);
      wait_for(1, 2'b11, n);
      chk("discharge_off", |dg, 1'b0);
      chk("pullup_on", &pu, 1'b1);
      chk("pulldown_off", |pd, 1'b0);
      open_load = 1'b1;
      wait_for(2, 2'b01, n);
      cyc(10);
      chk("no_pdn_opt", pdn[1], 1'b0);
      cell_mv = 3000;
      wait_for(1, 2'b01, n);
      cyc(30);
      chk("pdn_hold", ovd[0], 1'b1);
      open_load = 1'b0;
      ls_mv = 300;
      wait_for(2, 2'b00, n);
      wait_for(1, 2'b00, n);
      cell_mv = 2400;
      wait_for(1, 2'b11, n);
      cell_mv = 2600;
      cyc(30);
      chk("od_hold", &ovd, 1'b1);
      chk("od_monitor_off", |mon, 1'b0);
      cell_mv = 2400;
      ls_mv = -100;
      cyc(30);
      chk("od_hold_chg", &ovd, 1'b1);
      chk("od_monitor_chg", &mon, 1'b1);
      cell_mv = 2600;
      wait_for(1, 2'b00, n);
   endtask

   // Main sequence
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      cell_mv = 3700;
      ls_mv = 0;
      cur_mv = 0;
      temp_c = 25;
      open_load = 1'b0;
      err_total = 0;
      total_checks = 0;
      repeat (6) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_normal();
      t_gates_off();
      t_glitch();
      t_oc_release();
      t_od();
      report_and_stop();
   end
endmodule
`default_nettype wire
